/* logic/sepp_params.svh */
// Constants of the serial EEPROM instruction front end
// Function
// - Pause starts when the pause pin falls while serial clock is low.
// - Pause ends when the pause pin rises with clock low; position kept.
// - While paused the output floats and data and clock are ignored.
// - Chip select rising during a pause abandons the whole instruction.
// - Memory and status writes need a clock count that is a multiple of 8.
// - Data-changing instructions need the write enable latch set beforehand.
// - Latch clears at power-up and after disable, status or memory writes.
// - Chip select must rise after the last bit edge, before the next one.
// - Last bit is opcode or data byte bit eight; reads are exempt.
// - Protect field 00 none, 01 3000h up, 10 2000h up, 11 all.
// - Opcodes: set enable 06h, clear enable 04h, read status 05h.
// - Opcodes: write status 01h, read memory 03h, write memory 02h.
// - Unknown opcode deselects the device until the next select edge.
// - Set-enable is the only way to set the latch, then idle.
// - Clear-enable resets the latch, then idle until deselected.
// - Status read works anytime and repeats the byte while selected.
// - Write-in-progress reads 1 during a write cycle, otherwise 0.
// - Write-enable bit mirrors the latch; at 0 writes are refused.
// - Protect bits are non-volatile, set only by status write, unless locked.
// - Disable bit 1 with protect pin low makes status bits read-only.
// - Input sampled on rising clock; output changes after falling clock.
// - Deselected output floats; after power-up wait for a select edge.
// - Power-on clears enable and busy bits, keeps non-volatile bits.
`ifndef SEPP_PARAMS_SVH
`define SEPP_PARAMS_SVH

`define SEPP_OPC_SET_WE     8'h06
`define SEPP_OPC_CLR_WE     8'h04
`define SEPP_OPC_RD_STATUS  8'h05
`define SEPP_OPC_WR_STATUS  8'h01
`define SEPP_OPC_RD_MEM     8'h03
`define SEPP_OPC_WR_MEM     8'h02

`define SEPP_ST_WIP_BIT     0
`define SEPP_ST_WEL_BIT     1
`define SEPP_ST_BP_LO_BIT   2
`define SEPP_ST_BP_HI_BIT   3
`define SEPP_ST_STATUS_WRITE_DISABLE_BIT    7

`define SEPP_PROT_QUARTER   14'h3000
`define SEPP_PROT_HALF      14'h2000

`define SEPP_BYTES_OPCODE   3'h1
`define SEPP_BYTES_WRITE_STATUS_CMD     3'h2
`define SEPP_BYTES_WRITE    3'h4

`define SEPP_CLK_NS         100
`define SEPP_TW_NS          5000000
`define SEPP_TW_CYCLES      ((`SEPP_TW_NS + `SEPP_CLK_NS - 1) / `SEPP_CLK_NS)

`endif

/* logic/sepp_pkg.sv */
// Types and opcode decoder of the serial EEPROM instruction front end
`include "sepp_params.svh"
package sepp_pkg;

   typedef enum logic [2:0] {
      SEPP_OP_NONE   = 3'h0,
      SEPP_OP_SET_WE = 3'h1,
      SEPP_OP_CLR_WE = 3'h2,
      SEPP_OP_RD_ST  = 3'h3,
      SEPP_OP_WR_ST  = 3'h4,
      SEPP_OP_RD_MEM = 3'h5,
      SEPP_OP_WR_MEM = 3'h6,
      SEPP_OP_BAD    = 3'h7
   } sepp_op_type;

   typedef enum logic [1:0] {
      SEPP_CYC_IDLE   = 2'h0,
      SEPP_CYC_STATUS = 2'h1,
      SEPP_CYC_MEMORY = 2'h2
   } sepp_cyc_type;

   function automatic sepp_op_type sepp_decode(input logic [7:0] opc);
      sepp_op_type op;
      op = SEPP_OP_BAD;
      case (opc)
         `SEPP_OPC_SET_WE:    op = SEPP_OP_SET_WE;
         `SEPP_OPC_CLR_WE:    op = SEPP_OP_CLR_WE;
         `SEPP_OPC_RD_STATUS: op = SEPP_OP_RD_ST;
         `SEPP_OPC_WR_STATUS: op = SEPP_OP_WR_ST;
         `SEPP_OPC_RD_MEM:    op = SEPP_OP_RD_MEM;
         `SEPP_OPC_WR_MEM:    op = SEPP_OP_WR_MEM;
         default:             op = SEPP_OP_BAD;
      endcase
      return op;
   endfunction : sepp_decode

endpackage : sepp_pkg

/* logic/sepp_core.sv */
// Serial EEPROM instruction front end: pause, decode, latch, protection
`timescale 1ns/1ps
`default_nettype none
`include "sepp_params.svh"
module sepp_core
   import sepp_pkg::*;
#(
   parameter int TW_CYCLES = `SEPP_TW_CYCLES
) (
   input  wire logic        ref_clk_in,
   input  wire logic        reset_in,
   input  wire logic        ser_clk_in,
   input  wire logic        sel_n_in,
   input  wire logic        ser_data_in,
   input  wire logic        pause_n_in,
   input  wire logic        wp_n_in,
   input  wire logic [2:0]  nv_status_in,
   output var  logic        ser_data_out,
   output var  logic        ser_oe_out,
   output var  logic [7:0]  status_out,
   output var  logic [2:0]  nv_status_out,
   output var  logic        nv_store_out,
   output var  logic        mem_write_go_out,
   output var  logic [13:0] mem_write_addr_out
);

   generate
      if (TW_CYCLES < 1) begin : g_bad_tw
         $error("TW_CYCLES must be at least one cycle");
      end
   endgenerate

   // ---------------- Link side, clocked by the serial clock ----------------
   logic        link_rst;
   logic        armed_reg;
   logic [2:0]  bit_cnt_reg;
   logic [2:0]  byte_cnt_reg;
   logic [6:0]  shift_reg;
   sepp_op_type op_reg;
   logic [7:0]  data_byte_reg;
   logic [7:0]  addr_lo_reg;
   logic [7:0]  st_meta_reg;
   logic [7:0]  st_link_reg;
   logic [2:0]  out_cnt_reg;
   logic [6:0]  out_shift_reg;
   logic        link_paused;
   logic        rd_status_act;
   logic        oe_off;

   // Deselect ends the frame at once; power-on reset also lands here
   assign link_rst      = sel_n_in | reset_in;
   // Sampled at the rising edge: pin low here means pause is in force
   assign link_paused   = ~pause_n_in;
   assign rd_status_act = (op_reg == SEPP_OP_RD_ST);
   // A pause floats the pin at once, not only at the next falling edge
   assign oe_off        = link_rst | link_paused;

   // Select only counts after a falling select edge following power-up
   always_ff @(negedge sel_n_in or posedge reset_in) begin
      if (reset_in) begin
         armed_reg <= 1'b0;
      end else begin
         armed_reg <= 1'b1;
      end
   end

   // Input shifter and byte counter; freeze while paused, clear while deselected
   always_ff @(posedge ser_clk_in or posedge link_rst) begin
      if (link_rst) begin
         bit_cnt_reg  <= 3'h0;
         byte_cnt_reg <= 3'h0;
         shift_reg    <= 7'h00;
      end else if (armed_reg && !link_paused &&
                   op_reg != SEPP_OP_BAD) begin
         shift_reg   <= {shift_reg[5:0], ser_data_in};
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
         if (bit_cnt_reg == 3'h7 && byte_cnt_reg != 3'h7) begin
            byte_cnt_reg <= byte_cnt_reg + 3'h1;
         end
      end
   end

   // Opcode decode and capture of the data and address bytes
   always_ff @(posedge ser_clk_in or posedge link_rst) begin
      if (link_rst) begin
         op_reg        <= SEPP_OP_NONE;
         data_byte_reg <= 8'h00;
         addr_lo_reg   <= 8'h00;
      end else if (armed_reg && !link_paused && op_reg != SEPP_OP_BAD &&
                   bit_cnt_reg == 3'h7) begin
         unique case (byte_cnt_reg)
            3'h0: op_reg <= sepp_decode({shift_reg, ser_data_in});
            3'h1: data_byte_reg <= {shift_reg, ser_data_in};
            3'h2: addr_lo_reg <= {shift_reg, ser_data_in};
            default: ;
         endcase
      end
   end

   // Status byte brought over to the link clock, bit by bit
   always_ff @(posedge ser_clk_in or posedge reset_in) begin
      if (reset_in) begin
         st_meta_reg <= 8'h00;
         st_link_reg <= 8'h00;
      end else begin
         st_meta_reg <= status_out;
         st_link_reg <= st_meta_reg;
      end
   end

   // Status read: a new bit after each falling edge, byte repeats
   always_ff @(negedge ser_clk_in or posedge link_rst) begin
      if (link_rst) begin
         ser_data_out  <= 1'b0;
         out_cnt_reg   <= 3'h0;
         out_shift_reg <= 7'h00;
      end else if (!link_paused && rd_status_act) begin
         out_cnt_reg <= out_cnt_reg + 3'h1;
         if (out_cnt_reg == 3'h0) begin
            ser_data_out  <= st_link_reg[7];
            out_shift_reg <= st_link_reg[6:0];
         end else begin
            ser_data_out  <= out_shift_reg[6];
            out_shift_reg <= {out_shift_reg[5:0], 1'b0};
         end
      end
   end

   // Output enable; after a pause the pin drives again at the next falling
   // edge, so a master should resume a read only on a byte it may drop
   always_ff @(negedge ser_clk_in or posedge oe_off) begin
      if (oe_off) begin
         ser_oe_out <= 1'b0;
      end else begin
         ser_oe_out <= rd_status_act;
      end
   end

   // ------------- Frame end, clocked by the rising select edge -------------
   logic        cap_tgl_reg;
   sepp_op_type cap_op_reg;
   logic        cap_aligned_reg;
   logic [2:0]  cap_bytes_reg;
   logic [7:0]  cap_data_reg;
   logic [13:0] cap_addr_reg;

   // Link counters are still intact here; their reset lands after this
   always_ff @(posedge sel_n_in or posedge reset_in) begin
      if (reset_in) begin
         cap_tgl_reg     <= 1'b0;
         cap_op_reg      <= SEPP_OP_NONE;
         cap_aligned_reg <= 1'b0;
         cap_bytes_reg   <= 3'h0;
         cap_data_reg    <= 8'h00;
         cap_addr_reg    <= 14'h0000;
      end else if (armed_reg && pause_n_in) begin
         cap_tgl_reg     <= ~cap_tgl_reg;
         cap_op_reg      <= op_reg;
         cap_aligned_reg <= (bit_cnt_reg == 3'h0);
         cap_bytes_reg   <= byte_cnt_reg;
         cap_data_reg    <= data_byte_reg;
         cap_addr_reg    <= {data_byte_reg[5:0], addr_lo_reg};
      end
   end

   // --------------- System side, clocked by the reference clock ------------
   logic         tgl_meta_reg;
   logic         tgl_sync_reg;
   logic         tgl_seen_reg;
   logic         wp_meta_reg;
   logic         wp_sync_reg;
   logic         nv_loaded_reg;
   logic         wel_reg;
   logic [1:0]   bp_reg;
   logic         status_write_disable_reg;
   sepp_cyc_type cyc_reg;
   logic [31:0]  cyc_cnt_reg;
   logic [2:0]   pend_nv_reg;
   logic         commit;
   logic         hw_protected;
   logic         cyc_done;
   logic         ok_set_we;
   logic         ok_clr_we;
   logic         ok_wr_st;
   logic         ok_wr_mem;

   function automatic logic sepp_in_prot(input logic [1:0]  bp,
                                         input logic [13:0] addr);
      logic hit;
      hit = 1'b0;
      unique case (bp)
         2'b00: hit = 1'b0;
         2'b01: hit = (addr >= `SEPP_PROT_QUARTER);
         2'b10: hit = (addr >= `SEPP_PROT_HALF);
         2'b11: hit = 1'b1;
      endcase
      return hit;
   endfunction : sepp_in_prot

   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         tgl_meta_reg <= 1'b0;
         tgl_sync_reg <= 1'b0;
         tgl_seen_reg <= 1'b0;
      end else begin
         tgl_meta_reg <= cap_tgl_reg;
         tgl_sync_reg <= tgl_meta_reg;
         tgl_seen_reg <= tgl_sync_reg;
      end
   end

   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         wp_meta_reg <= 1'b1;
         wp_sync_reg <= 1'b1;
      end else begin
         wp_meta_reg <= wp_n_in;
         wp_sync_reg <= wp_meta_reg;
      end
   end

   assign commit       = tgl_sync_reg ^ tgl_seen_reg;
   assign hw_protected = status_write_disable_reg & ~wp_sync_reg;
   assign cyc_done     = (cyc_reg != SEPP_CYC_IDLE) &&
                         (cyc_cnt_reg == 32'(TW_CYCLES - 1));

   // Commands need a frame ended on a byte edge, right after their last bit
   assign ok_set_we = commit && cyc_reg == SEPP_CYC_IDLE &&
                      cap_op_reg == SEPP_OP_SET_WE && cap_aligned_reg &&
                      cap_bytes_reg == `SEPP_BYTES_OPCODE;
   assign ok_clr_we = commit && cyc_reg == SEPP_CYC_IDLE &&
                      cap_op_reg == SEPP_OP_CLR_WE && cap_aligned_reg &&
                      cap_bytes_reg == `SEPP_BYTES_OPCODE;
   assign ok_wr_st  = commit && cyc_reg == SEPP_CYC_IDLE &&
                      cap_op_reg == SEPP_OP_WR_ST && cap_aligned_reg &&
                      cap_bytes_reg == `SEPP_BYTES_WRITE_STATUS_CMD &&
                      wel_reg && !hw_protected;
   assign ok_wr_mem = commit && cyc_reg == SEPP_CYC_IDLE &&
                      cap_op_reg == SEPP_OP_WR_MEM && cap_aligned_reg &&
                      cap_bytes_reg >= `SEPP_BYTES_WRITE && wel_reg &&
                      !sepp_in_prot(bp_reg, cap_addr_reg);

   // Write-enable latch
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         wel_reg <= 1'b0;
      end else if (ok_set_we) begin
         wel_reg <= 1'b1;
      end else if (ok_clr_we || cyc_done) begin
         wel_reg <= 1'b0;
      end
   end

   // Self-timed write cycle drives the busy bit
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         cyc_reg     <= SEPP_CYC_IDLE;
         cyc_cnt_reg <= 32'h0000_0000;
         pend_nv_reg <= 3'h0;
      end else begin
         unique case (cyc_reg)
            SEPP_CYC_IDLE: begin
               cyc_cnt_reg <= 32'h0000_0000;
               if (ok_wr_st) begin
                  cyc_reg     <= SEPP_CYC_STATUS;
                  pend_nv_reg <= {cap_data_reg[`SEPP_ST_STATUS_WRITE_DISABLE_BIT],
                                  cap_data_reg[`SEPP_ST_BP_HI_BIT],
                                  cap_data_reg[`SEPP_ST_BP_LO_BIT]};
               end else if (ok_wr_mem) begin
                  cyc_reg <= SEPP_CYC_MEMORY;
               end
            end
            SEPP_CYC_STATUS, SEPP_CYC_MEMORY: begin
               if (cyc_done) begin
                  cyc_reg <= SEPP_CYC_IDLE;
               end else begin
                  cyc_cnt_reg <= cyc_cnt_reg + 32'h0000_0001;
               end
            end
            default: cyc_reg <= SEPP_CYC_IDLE;
         endcase
      end
   end

   // Non-volatile bits: loaded from storage once after reset, then set only by a finished status write
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         nv_loaded_reg <= 1'b0;
         status_write_disable_reg      <= 1'b0;
         bp_reg        <= 2'b00;
         nv_store_out  <= 1'b0;
      end else begin
         nv_store_out <= 1'b0;
         if (!nv_loaded_reg) begin
            nv_loaded_reg <= 1'b1;
            {status_write_disable_reg, bp_reg} <= nv_status_in;
         end else if (cyc_done && cyc_reg == SEPP_CYC_STATUS) begin
            {status_write_disable_reg, bp_reg} <= pend_nv_reg;
            nv_store_out       <= 1'b1;
         end
      end
   end

   // Memory write start toward the array
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         mem_write_go_out   <= 1'b0;
         mem_write_addr_out <= 14'h0000;
      end else begin
         mem_write_go_out <= ok_wr_mem;
         if (ok_wr_mem) begin
            mem_write_addr_out <= cap_addr_reg;
         end
      end
   end

   // Status byte image; unused bits read as zero
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         status_out    <= 8'h00;
         nv_status_out <= 3'h0;
      end else begin
         status_out <= 8'h00;
         status_out[`SEPP_ST_WIP_BIT]   <= (cyc_reg != SEPP_CYC_IDLE);
         status_out[`SEPP_ST_WEL_BIT]   <= wel_reg;
         status_out[`SEPP_ST_BP_LO_BIT] <= bp_reg[0];
         status_out[`SEPP_ST_BP_HI_BIT] <= bp_reg[1];
         status_out[`SEPP_ST_STATUS_WRITE_DISABLE_BIT]  <= status_write_disable_reg;
         nv_status_out <= {status_write_disable_reg, bp_reg};
      end
   end

endmodule : sepp_core
`default_nettype wire

/* verif/sepp_core_assertions.sv */
// Port-level checker of the serial EEPROM instruction front end
`timescale 1ns/1ps
`default_nettype none
module sepp_core_chk #(
   parameter int TW_CYCLES = 20
) (
   input wire logic        ref_clk_in,
   input wire logic        reset_in,
   input wire logic        ser_clk_in,
   input wire logic        sel_n_in,
   input wire logic        ser_data_in,
   input wire logic        pause_n_in,
   input wire logic        wp_n_in,
   input wire logic [2:0]  nv_status_in,
   input wire logic        ser_data_out,
   input wire logic        ser_oe_out,
   input wire logic [7:0]  status_out,
   input wire logic [2:0]  nv_status_out,
   input wire logic        nv_store_out,
   input wire logic        mem_write_go_out,
   input wire logic [13:0] mem_write_addr_out
);
   localparam int BUSY_LO = TW_CYCLES - 2;
   localparam int BUSY_HI = TW_CYCLES + 2;
   logic [31:0] busy_reg;

   // Length of the current busy stretch
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         busy_reg <= 32'h0;
      end else if (status_out[0]) begin
         busy_reg <= busy_reg + 32'h1;
      end else begin
         busy_reg <= 32'h0;
      end
   end

   chk_desel_quiet: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      sel_n_in && $past(sel_n_in) |-> !ser_oe_out) else $error("output driven while deselected");
   chk_pause_float: assert property (@(posedge ser_clk_in)
      disable iff (reset_in) !pause_n_in |-> !ser_oe_out)
      else $error("output driven in pause");
   chk_spare_zero: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      status_out[6:4] == 3'h0) else $error("spare status bits set");
   chk_busy_length: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      $fell(status_out[0]) |-> busy_reg >= BUSY_LO && busy_reg <= BUSY_HI)
      else $error("busy stretch has wrong length");
   chk_store_clears: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      nv_store_out |-> ##[1:2] status_out[1:0] == 2'b00) else $error("latch not cleared");
   chk_store_busy: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      nv_store_out |-> $past(status_out[0])) else $error("store outside write cycle");
   chk_write_latch: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      mem_write_go_out |-> $past(status_out[1])) else $error("write without latch");
   chk_write_range: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      mem_write_go_out |-> status_out[3:2] == 2'b00
      || (status_out[3:2] == 2'b01 && mem_write_addr_out < 14'h3000)
      || (status_out[3:2] == 2'b10 && mem_write_addr_out < 14'h2000))
      else $error("write into protected range");
   chk_write_busy: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      mem_write_go_out |-> ##[1:3] status_out[0]) else $error("write cycle not busy");
   chk_latch_source: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      $rose(status_out[1]) |-> sel_n_in && $past(sel_n_in, 3) && !status_out[0])
      else $error("latch set outside frame end");

   cov_latch_set: cover property (@(posedge ref_clk_in) $rose(status_out[1]));
   cov_store: cover property (@(posedge ref_clk_in) nv_store_out);
   cov_mem_write: cover property (@(posedge ref_clk_in) mem_write_go_out);
   cov_pause: cover property (@(posedge ser_clk_in) !pause_n_in);
endmodule : sepp_core_chk

bind sepp_core sepp_core_chk #(.TW_CYCLES(TW_CYCLES)) u_chk (
   .ref_clk_in, .reset_in, .ser_clk_in, .sel_n_in, .ser_data_in,
   .pause_n_in, .wp_n_in, .nv_status_in, .ser_data_out, .ser_oe_out,
   .status_out, .nv_status_out, .nv_store_out, .mem_write_go_out,
   .mem_write_addr_out
);
`default_nettype wire

/* verif/sepp_master_model.sv */
// Serial bus master model driving the EEPROM front end
`timescale 1ns/1ps
`default_nettype none
module sepp_master_model (
   output var  logic sck_out,
   output var  logic sel_n_out,
   output var  logic mosi_out,
   output var  logic pause_n_out,
   input  wire logic miso_in,
   input  wire logic oe_in
);
   initial begin
      sck_out = 1'b0;
      sel_n_out = 1'b1;
      mosi_out = 1'b0;
      pause_n_out = 1'b1;
   end

   // Sends n bits MSB first; pauses before bit pause_at, deselects if abort
   task automatic xfer(input logic [39:0] bits, input int n, input int pause_at,
                       input bit abort, output logic [15:0] rx);
      rx = 16'h0000;
      #7 sel_n_out = 1'b0;
      #40;
      for (int i = n - 1; i >= 0; i--) begin
         if (i == pause_at) begin
            pause_n_out = 1'b0;
            mosi_out = ~mosi_out;
            #32 sck_out = 1'b1;
            #32 sck_out = 1'b0;
            #32;
            if (abort) begin
               sel_n_out = 1'b1;
               #32 pause_n_out = 1'b1;
               #1000;
               return;
            end
            pause_n_out = 1'b1;
            #32;
         end
         mosi_out = bits[i];
         #32 sck_out = 1'b1;
         rx = {rx[14:0], oe_in ? miso_in : 1'bx};
         #32 sck_out = 1'b0;
      end
      #16 sel_n_out = 1'b1;
      mosi_out = ~mosi_out;
      #1000;
   endtask : xfer
endmodule : sepp_master_model
`default_nettype wire

/* verif/tb_sepp_core.sv */
// Self-checking testbench of the serial EEPROM front end
`timescale 1ns/1ps
`default_nettype none
`include "sepp_params.svh"
module tb_sepp_core;
   localparam int TW = 40;
   logic        ref_clk_in   = 1'b0;
   logic        reset_in     = 1'b1;
   logic        wp_n_in      = 1'b1;
   logic [2:0]  nv_status_in = 3'h1;
   wire logic   sck, sel_n, mosi, pause_n;
   wire logic   ser_data_out, ser_oe_out, nv_store_out, mem_write_go_out;
   wire logic [7:0]  status_out;
   wire logic [2:0]  nv_status_out;
   wire logic [13:0] mem_write_addr_out;
   wire logic [15:0] st16;
   logic [13:0] go_addr;
   logic [15:0] rx;
   logic [13:0] addrs [6] = '{14'h0000, 14'h1fff, 14'h2000, 14'h2fff,
                              14'h3000, 14'h3fff};
   int          miscompares = 0;
   int          num_checks = 0;
   int          go_cnt = 0;
   int          cycles = 0;

   assign st16 = {8'h00, status_out};
   always #50 ref_clk_in = ~ref_clk_in;

   sepp_core #(.TW_CYCLES(TW)) u_dut (
      .ref_clk_in         (ref_clk_in),
      .reset_in           (reset_in),
      .ser_clk_in         (sck),
      .sel_n_in           (sel_n),
      .ser_data_in        (mosi),
      .pause_n_in         (pause_n),
      .wp_n_in            (wp_n_in),
      .nv_status_in       (nv_status_in),
      .ser_data_out       (ser_data_out),
      .ser_oe_out         (ser_oe_out),
      .status_out         (status_out),
      .nv_status_out      (nv_status_out),
      .nv_store_out       (nv_store_out),
      .mem_write_go_out   (mem_write_go_out),
      .mem_write_addr_out (mem_write_addr_out)
   );

   sepp_master_model u_mst (
      .sck_out     (sck),
      .sel_n_out   (sel_n),
      .mosi_out    (mosi),
      .pause_n_out (pause_n),
      .miso_in     (ser_data_out),
      .oe_in       (ser_oe_out)
   );

   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test

   task automatic check(input logic [15:0] got, input logic [15:0] exp,
                        input string what);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what,
                  got, exp);
      end
   endtask : check

   task automatic frame(input logic [39:0] bits, input int n);
      u_mst.xfer(bits, n, -1, 1'b0, rx);
   endtask : frame

   task automatic set_write_enable_cmd();
      frame(`SEPP_OPC_SET_WE, 8);
   endtask : set_write_enable_cmd

   task automatic wait_idle();
      for (int i = 0; i < 200 && status_out[0] !== 1'b0; i++) begin
         @(posedge ref_clk_in);
      end
   endtask : wait_idle

   task automatic write_status_cmd(input logic [7:0] d);
      set_write_enable_cmd();
      frame({`SEPP_OPC_WR_STATUS, d}, 16);
      wait_idle();
   endtask : write_status_cmd

   // Counts write-cycle starts and keeps the last address
   always @(posedge ref_clk_in) begin
      cycles++;
      if (mem_write_go_out === 1'b1) begin
         go_cnt++;
         go_addr = mem_write_addr_out;
      end
      if (cycles == 10000) begin
         miscompares++;
         stop_test();
      end
   end

   initial begin
      int   n0;
      logic ok;
      repeat (8) @(posedge ref_clk_in);
      reset_in <= 1'b0;
      repeat (6) @(posedge ref_clk_in);
      check(st16, 16'h0004, "reset status");
      frame(`SEPP_OPC_SET_WE >> 1, 7);
      check(st16, 16'h0004, "short frame");
      frame({`SEPP_OPC_SET_WE, 1'b0}, 9);
      check(st16, 16'h0004, "long frame");
      frame({8'h07, `SEPP_OPC_SET_WE}, 16);
      check(st16, 16'h0004, "unknown opcode");
      set_write_enable_cmd();
      check(st16, 16'h0006, "set enable");
      frame(`SEPP_OPC_CLR_WE, 8);
      check(st16, 16'h0004, "clear enable");
      set_write_enable_cmd();
      u_mst.xfer({`SEPP_OPC_RD_STATUS, 16'h0000}, 24, -1, 1'b0, rx);
      check(rx, 16'h0606, "repeated status");
      u_mst.xfer({`SEPP_OPC_RD_STATUS, 16'h0000}, 24, 20, 1'b0, rx);
      check(rx, 16'h0606, "paused status");
      u_mst.xfer({`SEPP_OPC_RD_STATUS, 16'h0000}, 24, 12, 1'b1, rx);
      check(rx, 16'h0000, "read before pause");
      u_mst.xfer(`SEPP_OPC_CLR_WE, 8, 0, 1'b1, rx);
      check(st16, 16'h0006, "abandoned frame");
      frame({`SEPP_OPC_WR_STATUS, 8'h8c}, 16);
      u_mst.xfer({`SEPP_OPC_RD_STATUS, 8'h00}, 16, -1, 1'b0, rx);
      check({8'h00, rx[7:0]}, 16'h0007, "busy status");
      wait_idle();
      check(st16, 16'h008c, "status written");
      check({13'h0000, nv_status_out}, 16'h0007, "stored bits");
      frame({`SEPP_OPC_WR_STATUS, 8'h00}, 16);
      wait_idle();
      check(st16, 16'h008c, "write without latch");
      @(posedge ref_clk_in) wp_n_in <= 1'b0;
      write_status_cmd(8'h00);
      check(st16, 16'h008e, "locked status");
      @(posedge ref_clk_in) wp_n_in <= 1'b1;
      write_status_cmd(8'h00);
      check(st16, 16'h0000, "unlocked status");
      for (int bp = 0; bp < 4; bp++) begin
         write_status_cmd({4'h0, 2'(bp), 2'b00});
         foreach (addrs[k]) begin
            set_write_enable_cmd();
            n0 = go_cnt;
            frame({`SEPP_OPC_WR_MEM, 2'b00, addrs[k], 8'h5a}, 32);
            wait_idle();
            ok = bp == 0 || (bp == 1 && addrs[k] < 14'h3000)
                 || (bp == 2 && addrs[k] < 14'h2000);
            check(16'(go_cnt - n0), {15'h0000, ok}, "write start");
            if (ok) check({2'b00, go_addr}, {2'b00, addrs[k]}, "address");
            check({15'h0000, status_out[1]}, {15'h0000, !ok}, "latch");
         end
      end
      write_status_cmd(8'h00);
      set_write_enable_cmd();
      n0 = go_cnt;
      frame({`SEPP_OPC_WR_MEM, 16'h0000, 8'h5a, 4'h0}, 36);
      wait_idle();
      check(16'(go_cnt - n0), 16'h0000, "odd bit count");
      stop_test();
   end
endmodule : tb_sepp_core
`default_nettype wire
